//--- logic/tcm_ctrl.sv
// mode registers, channel scan sequencer and output words of the thermocouple block
//
// Function
// - bit 0 picks 20 ms or 16.67 ms
// - bit 7 halves the conversion period
// - type field bits 1:0 group1, 3:2 group2
// - type codes: 00 L, 01 J, 10 K
// - type 11 reports -3276.8
// - raw output ignores the sensor type
// - comp bit outputs compensation temperature
// - raw bit outputs scaled voltage, else temperature
// - raw value is 2 uV per count
// - compensation temperature never in raw form
// - mode4 bit 5 picks external compensation
// - external value per channel feeds calculation
// - eight signed input and output words
// - raw and measured compensation stay available
// - format set by type and format together
// - echo mode 2-4 once applied
// - 7FFF above range, 8000 below range
module tcm_ctrl
  import tcm_pkg::*;
#(
  parameter logic [TIMER_W-1:0] CYC_50 = TIMER_W'(CYC50),
  parameter logic [TIMER_W-1:0] CYC_60 = TIMER_W'(CYC60)
)(
  input  wire logic                              clock_i,
  input  wire logic                              sys_rst_i,
  input  wire logic                              mode_wr_i,
  input  wire logic [1:0]                        mode_sel_i,
  input  wire logic [7:0]                        mode_data_i,
  input  wire logic [NUM_CH-1:0][WORD_W-1:0]     ext_ref_i,
  input  wire logic [NUM_CH-1:0][WORD_W-1:0]     adc_raw_i,
  input  wire logic [NUM_CH-1:0]                 adc_over_i,
  input  wire logic [NUM_CH-1:0]                 adc_under_i,
  input  wire logic [NUM_CH-1:0][WORD_W-1:0]     term_temp_i,
  output logic      [NUM_CH-1:0][WORD_W-1:0]     meas_word_o,
  output logic      [NUM_CH-1:0][WORD_W-1:0]     comp_word_o,
  output logic      [NUM_CH-1:0][WORD_W-1:0]     raw_word_o,
  output logic      [7:0]                        stat1_o,
  output logic      [7:0]                        stat2_o,
  output logic      [7:0]                        stat3_o,
  output logic      [7:0]                        stat4_o,
  output logic                                   conv_start_o,
  output logic      [CH_W-1:0]                   conv_ch_o
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_APPLY   = 3'b001,
    ST_CONVERT = 3'b010,
    ST_STORE   = 3'b100
  } tcm_state_t;

  tcm_state_t                   state;
  tcm_state_t                   next_state;
  logic [7:0]                   mode1_pend;
  logic [7:0]                   mode2_pend;
  logic [7:0]                   mode3_pend;
  logic [7:0]                   mode4_pend;
  logic [7:0]                   next_mode1_pend;
  logic [7:0]                   next_mode2_pend;
  logic [7:0]                   next_mode3_pend;
  logic [7:0]                   next_mode4_pend;
  logic [TIMER_W-1:0]           timer;
  logic [TIMER_W-1:0]           next_timer;
  logic [TIMER_W-1:0]           period;
  logic [CH_W-1:0]              ch;
  logic [CH_W-1:0]              next_ch;
  logic                         next_conv_start;
  logic [7:0]                   next_stat2;
  logic [7:0]                   next_stat3;
  logic [7:0]                   next_stat4;
  logic [NUM_CH-1:0][WORD_W-1:0] next_meas;
  logic [NUM_CH-1:0][WORD_W-1:0] next_comp;
  logic [NUM_CH-1:0][WORD_W-1:0] next_raw;
  logic                         grp2;
  logic                         store_en;
  logic signed [WORD_W-1:0]     comp_now;

  tcm_calc_if cif ();

  // ****************************************************************
  // mode register writes from the controller
  // ****************************************************************

  // reserved bits land as zero whatever the host wrote
  always_comb begin
    next_mode1_pend = mode1_pend;
    next_mode2_pend = mode2_pend;
    next_mode3_pend = mode3_pend;
    next_mode4_pend = mode4_pend;
    if (mode_wr_i) begin
      unique case (mode_sel_i)
        MODE1_IDX: next_mode1_pend = mode_data_i & MODE1_MASK;
        MODE2_IDX: next_mode2_pend = mode_data_i & MODE2_MASK;
        MODE3_IDX: next_mode3_pend = mode_data_i & MODE3_MASK;
        MODE4_IDX: next_mode4_pend = mode_data_i & MODE4_MASK;
      endcase
    end
  end

  // pending mode register storage
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      mode1_pend <= MODE_RST;
      mode2_pend <= MODE_RST;
      mode3_pend <= MODE_RST;
      mode4_pend <= MODE_RST;
    end else begin
      mode1_pend <= next_mode1_pend;
      mode2_pend <= next_mode2_pend;
      mode3_pend <= next_mode3_pend;
      mode4_pend <= next_mode4_pend;
    end
  end

  // ****************************************************************
  // per channel operands for the calculator
  // ****************************************************************
  assign grp2     = ch[GRP_BIT];
  assign comp_now = stat4_o[M4_REMOTE] ? ext_ref_i[ch] : term_temp_i[ch];

  // group fields picked from the applied settings
  assign cif.raw       = adc_raw_i[ch];
  assign cif.comp      = comp_now;
  assign cif.sens_type = grp2 ? stat2_o[M2_GRP2_LSB +: 2]
                              : stat2_o[M2_GRP1_LSB +: 2];
  assign cif.comp_sel  = grp2 ? stat3_o[M3_G2_COMP] : stat3_o[M3_G1_COMP];
  assign cif.raw_sel   = grp2 ? stat3_o[M3_G2_RAW]  : stat3_o[M3_G1_RAW];
  assign cif.over      = adc_over_i[ch];
  assign cif.under     = adc_under_i[ch];

  tcm_calc u_calc (
    .cif (cif.calc)
  );

  // ****************************************************************
  // scan sequencer
  // ****************************************************************

  // conversion period from the pending first mode register
  always_comb begin
    period = mode1_pend[M1_HUM60] ? CYC_60 : CYC_50;
    if (mode1_pend[M1_HALF]) begin
      period = period >> 1;
    end
  end

  // apply settings, time one conversion, store the result
  always_comb begin
    next_state      = state;
    next_timer      = timer;
    next_ch         = ch;
    next_stat2      = stat2_o;
    next_stat3      = stat3_o;
    next_stat4      = stat4_o;
    next_conv_start = 1'b0;
    store_en        = 1'b0;
    unique case (state)
      ST_APPLY: begin
        next_stat2      = mode2_pend;
        next_stat3      = mode3_pend;
        next_stat4      = mode4_pend;
        next_timer      = period;
        next_conv_start = 1'b1;
        next_state      = ST_CONVERT;
      end
      ST_CONVERT: begin
        next_timer = timer - TIMER_W'(1);
        if (timer == TIMER_W'(1)) begin
          next_state = ST_STORE;
        end
      end
      ST_STORE: begin
        store_en   = 1'b1;
        next_ch    = ch + CH_W'(1);
        next_state = ST_APPLY;
      end
    endcase
  end

  // sequencer and status registers
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      state        <= ST_APPLY;
      timer        <= '0;
      ch           <= '0;
      stat2_o      <= MODE_RST;
      stat3_o      <= MODE_RST;
      stat4_o      <= MODE_RST;
      conv_start_o <= 1'b0;
      conv_ch_o    <= '0;
      stat1_o      <= STAT1_OK;
    end else begin
      state        <= next_state;
      timer        <= next_timer;
      ch           <= next_ch;
      stat2_o      <= next_stat2;
      stat3_o      <= next_stat3;
      stat4_o      <= next_stat4;
      conv_start_o <= next_conv_start;
      conv_ch_o    <= next_ch;
      stat1_o      <= STAT1_OK;
    end
  end

  // ****************************************************************
  // channel words
  // ****************************************************************

  // only the channel just converted is updated
  always_comb begin
    next_meas = meas_word_o;
    next_comp = comp_word_o;
    next_raw  = raw_word_o;
    if (store_en) begin
      next_meas[ch] = cif.result;
      next_comp[ch] = term_temp_i[ch];
      next_raw[ch]  = adc_raw_i[ch];
    end
  end

  // registered input area words
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      meas_word_o <= '0;
      comp_word_o <= '0;
      raw_word_o  <= '0;
    end else begin
      meas_word_o <= next_meas;
      comp_word_o <= next_comp;
      raw_word_o  <= next_raw;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_enter_convert;
    state == ST_APPLY ##1 state == ST_CONVERT;
  endsequence

  sequence s_store_step;
    state == ST_STORE ##1 state == ST_APPLY;
  endsequence

  property p_period(logic hum60, logic half, logic [TIMER_W-1:0] cyc);
    (state == ST_APPLY && mode1_pend[M1_HUM60] == hum60 && mode1_pend[M1_HALF] == half)
      ##1 state == ST_CONVERT |-> timer == cyc;
  endproperty

  period_full_a: assert property (p_period(1'b0, 1'b0, CYC_50))
    else $error("full 50 Hz period wrong");
  period_60_a: assert property (p_period(1'b1, 1'b0, CYC_60))
    else $error("full 60 Hz period wrong");
  period_half_a: assert property (p_period(1'b0, 1'b1, CYC_50 >> 1))
    else $error("halved period wrong");
  period_h60_a: assert property (p_period(1'b1, 1'b1, CYC_60 >> 1))
    else $error("halved 60 Hz period wrong");

  scan_order_a: assert property (
    state == ST_CONVERT && timer == TIMER_W'(1) |=> s_store_step ##0 ch == $past(ch, 1) + CH_W'(1))
    else $error("scan did not store and advance");

  conv_pulse_a: assert property (
    s_enter_convert |-> conv_start_o && conv_ch_o == ch)
    else $error("conversion start pulse wrong");

  echo_apply_a: assert property (
    state == ST_APPLY |=> stat2_o == $past(mode2_pend) && stat3_o == $past(mode3_pend)
                          && stat4_o == $past(mode4_pend))
    else $error("status echo mismatch");

  comp_out_a: assert property (
    store_en && cif.comp_sel |=> meas_word_o[$past(ch)] == $past(comp_now))
    else $error("compensation output wrong");

  raw_out_a: assert property (
    store_en && cif.raw_sel && !cif.comp_sel && !cif.over && !cif.under
      |=> meas_word_o[$past(ch)] == $past(adc_raw_i[ch]))
    else $error("raw output wrong");

  bad_type_a: assert property (
    store_en && !cif.comp_sel && !cif.raw_sel && !cif.over && !cif.under
      && cif.sens_type == TCM_TYPE_BAD |=> meas_word_o[$past(ch)] == VAL_BADTYPE)
    else $error("invalid type value wrong");

  over_range_a: assert property (
    store_en && cif.over && !cif.comp_sel |=> meas_word_o[$past(ch)] == VAL_OVER)
    else $error("over range value wrong");

  comp_src_a: assert property (
    store_en && cif.comp_sel && stat4_o[M4_REMOTE]
      |=> meas_word_o[$past(ch)] == $past(ext_ref_i[ch]))
    else $error("external compensation not used");

endmodule : tcm_ctrl

//--- include/tcm_pkg.sv
// shared constants and types for the thermocouple input mode control block
package tcm_pkg;

  // ****************************************************************
  // clock and conversion timing
  // ****************************************************************
  localparam int CLK_NS       = 5;            // 200 MHz system clock
  localparam int T50_NS       = 20_000_000;   // 20 ms, 50 Hz hum rejection
  localparam int T60_NS       = 16_670_000;   // 16.67 ms, 60 Hz hum rejection
  localparam int TIMER_W      = 23;
  localparam int CYC50        = (T50_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYC60        = (T60_NS + CLK_NS - 1) / CLK_NS;

  // ****************************************************************
  // channels and words
  // ****************************************************************
  localparam int NUM_CH       = 8;
  localparam int CH_W         = 3;
  localparam int GRP_BIT      = 2;            // channel index bit naming the group
  localparam int WORD_W       = 16;

  // ****************************************************************
  // mode register slots on the status-out byte lane
  // ****************************************************************
  localparam logic [1:0] MODE1_IDX = 2'h0;
  localparam logic [1:0] MODE2_IDX = 2'h1;
  localparam logic [1:0] MODE3_IDX = 2'h2;
  localparam logic [1:0] MODE4_IDX = 2'h3;

  // writable bit masks, reserved bits forced low
  localparam logic [7:0] MODE1_MASK = 8'h81;
  localparam logic [7:0] MODE2_MASK = 8'h0F;
  localparam logic [7:0] MODE3_MASK = 8'h33;
  localparam logic [7:0] MODE4_MASK = 8'h3F;
  localparam logic [7:0] MODE_RST   = 8'h00;

  // field positions
  localparam int M1_HUM60     = 0;
  localparam int M1_HALF      = 7;
  localparam int M2_GRP1_LSB  = 0;
  localparam int M2_GRP2_LSB  = 2;
  localparam int M3_G1_COMP   = 0;
  localparam int M3_G2_COMP   = 1;
  localparam int M3_G1_RAW    = 4;
  localparam int M3_G2_RAW    = 5;
  localparam int M4_REMOTE    = 5;

  // ****************************************************************
  // sensor types and reported sentinels
  // ****************************************************************
  typedef enum logic [1:0] {
    TCM_TYPE_L   = 2'h0,
    TCM_TYPE_J   = 2'h1,
    TCM_TYPE_K   = 2'h2,
    TCM_TYPE_BAD = 2'h3
  } tcm_type_t;

  localparam logic signed [WORD_W-1:0] VAL_OVER    = 16'sh7FFF;
  localparam logic signed [WORD_W-1:0] VAL_UNDER   = 16'sh8000;
  localparam logic signed [WORD_W-1:0] VAL_BADTYPE = 16'sh8000;   // -3276.8 in 0.1 steps

  // linear slope, 0.1 degree per 2 uV count, scaled by 2^GAIN_SHIFT
  localparam int GAIN_SHIFT   = 8;
  localparam logic signed [8:0] GAIN_L = 9'sh061;
  localparam logic signed [8:0] GAIN_J = 9'sh062;
  localparam logic signed [8:0] GAIN_K = 9'sh07D;

  localparam logic [7:0] STAT1_OK = 8'h00;

endpackage : tcm_pkg

//--- include/tcm_calc_if.sv
// channel operands and result passed between the sequencer and the value calculator
interface tcm_calc_if;
  import tcm_pkg::*;
  logic signed [WORD_W-1:0] raw;        // voltage in 2 uV counts
  logic signed [WORD_W-1:0] comp;       // compensation temperature, 0.1 degree
  logic        [1:0]        sens_type;
  logic                     comp_sel;
  logic                     raw_sel;
  logic                     over;
  logic                     under;
  logic signed [WORD_W-1:0] result;

  modport ctl  (output raw, comp, sens_type, comp_sel, raw_sel, over, under,
                input  result);
  modport calc (input  raw, comp, sens_type, comp_sel, raw_sel, over, under,
                output result);
endinterface : tcm_calc_if

//--- logic/tcm_calc.sv
// output value calculation for one channel from its format settings
module tcm_calc
  import tcm_pkg::*;
(
  tcm_calc_if.calc cif
);

  // ****************************************************************
  // linear conversion of the scaled voltage
  // ****************************************************************
  logic signed [8:0]          gain;
  logic signed [WORD_W+8:0]   prod;
  logic signed [WORD_W:0]     delta;
  logic signed [WORD_W+1:0]   sum;
  logic signed [WORD_W-1:0]   temp;

  // slope per sensor type
  always_comb begin
    unique case (cif.sens_type)
      TCM_TYPE_J: gain = GAIN_J;
      TCM_TYPE_K: gain = GAIN_K;
      default:    gain = GAIN_L;
    endcase
  end

  // compensated temperature with saturation
  always_comb begin
    prod  = cif.raw * gain;
    delta = (WORD_W + 1)'(prod >>> GAIN_SHIFT);
    sum   = (WORD_W + 2)'(cif.comp) + (WORD_W + 2)'(delta);
    if (sum > (WORD_W + 2)'(VAL_OVER)) begin
      temp = VAL_OVER;
    end else if (sum < (WORD_W + 2)'(VAL_UNDER)) begin
      temp = VAL_UNDER;
    end else begin
      temp = sum[WORD_W-1:0];
    end
  end

  // ****************************************************************
  // format selection
  // ****************************************************************
  always_comb begin
    if (cif.comp_sel) begin
      cif.result = cif.comp;
    end else if (cif.over) begin
      cif.result = VAL_OVER;
    end else if (cif.under) begin
      cif.result = VAL_UNDER;
    end else if (cif.raw_sel) begin
      cif.result = cif.raw;
    end else if (cif.sens_type == TCM_TYPE_BAD) begin
      cif.result = VAL_BADTYPE;
    end else begin
      cif.result = temp;
    end
  end

endmodule : tcm_calc

//--- tb/tcm_host_model.sv
// controlling processor model: mode register writes and external reference words
module tcm_host_model
  import tcm_pkg::*;
(
  input  wire logic                          clock_i,
  output logic                               mode_wr_o,
  output logic      [1:0]                    mode_sel_o,
  output logic      [7:0]                    mode_data_o,
  output logic      [NUM_CH-1:0][WORD_W-1:0] ext_ref_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************************************
  // idle values from time zero
  // ****************************************************************
  initial begin
    mode_wr_o   = 1'b0;
    mode_sel_o  = 2'h0;
    mode_data_o = 8'h00;
    ext_ref_o   = '0;
  end

  // one mode byte, reserved bits always written as zero
  task automatic write_mode(input logic [1:0] sel, input logic [7:0] data);
    logic [7:0] mask;
    mask = (sel == MODE1_IDX) ? MODE1_MASK : (sel == MODE2_IDX) ? MODE2_MASK :
           (sel == MODE3_IDX) ? MODE3_MASK : MODE4_MASK;
    @(posedge clock_i);
    mode_wr_o   <= 1'b1;
    mode_sel_o  <= sel;
    mode_data_o <= data & mask;
    @(posedge clock_i);
    mode_wr_o   <= 1'b0;
  endtask : write_mode

  // per channel reference junction temperatures, signed 0.1 degree
  task automatic load_refs(input logic [NUM_CH-1:0][WORD_W-1:0] refs);
    @(posedge clock_i);
    ext_ref_o <= refs;
  endtask : load_refs
endmodule : tcm_host_model

//--- tb/tcm_tb_top.sv
// self-checking testbench of the thermocouple mode control block
module thermocouple_input_mode_control_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import tcm_pkg::*;

  typedef struct {
    logic [2:0]  ch;
    logic [15:0] meas;
    logic [15:0] comp;
    logic [15:0] raw;
  } tcm_note_t;

  localparam int P50 = 20;
  localparam int P60 = 16;

  logic                          clock_i;
  logic                          sys_rst_i;
  logic                          mode_wr;
  logic [1:0]                    mode_sel;
  logic [7:0]                    mode_data;
  logic [NUM_CH-1:0][WORD_W-1:0] ext_ref;
  logic [NUM_CH-1:0][WORD_W-1:0] adc_raw;
  logic [NUM_CH-1:0]             adc_over;
  logic [NUM_CH-1:0]             adc_under;
  logic [NUM_CH-1:0][WORD_W-1:0] term_temp;
  logic [NUM_CH-1:0][WORD_W-1:0] meas_word;
  logic [NUM_CH-1:0][WORD_W-1:0] comp_word;
  logic [NUM_CH-1:0][WORD_W-1:0] raw_word;
  logic [7:0]                    stat1, stat2, stat3, stat4;
  logic                          conv_start;
  logic [CH_W-1:0]               conv_ch;
  logic [CH_W-1:0]               last_ch = '0;
  tcm_note_t                     notes[$];
  int                            fails, compares;
  int                            seed;

  tcm_host_model i_host (.clock_i(clock_i), .mode_wr_o(mode_wr), .mode_sel_o(mode_sel),
                         .mode_data_o(mode_data), .ext_ref_o(ext_ref));

  tcm_ctrl #(.CYC_50(TIMER_W'(P50)), .CYC_60(TIMER_W'(P60))) i_dut (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .mode_wr_i(mode_wr), .mode_sel_i(mode_sel),
    .mode_data_i(mode_data), .ext_ref_i(ext_ref), .adc_raw_i(adc_raw),
    .adc_over_i(adc_over), .adc_under_i(adc_under), .term_temp_i(term_temp),
    .meas_word_o(meas_word), .comp_word_o(comp_word), .raw_word_o(raw_word),
    .stat1_o(stat1), .stat2_o(stat2), .stat3_o(stat3), .stat4_o(stat4),
    .conv_start_o(conv_start), .conv_ch_o(conv_ch));

  // ****************************************************************
  // clock, counts and closing
  // ****************************************************************
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test

  // expected reported word of one channel
  function automatic logic [15:0] exp_meas(input logic [1:0] t, input logic c, input logic r,
      input logic ov, input logic un, input logic rem, input logic [15:0] raw,
      input logic [15:0] term, input logic [15:0] ext);
    int comp, gain, sum;
    comp = rem ? int'($signed(ext)) : int'($signed(term));
    if (c) return rem ? ext : term;
    if (ov) return VAL_OVER;
    if (un) return VAL_UNDER;
    if (r) return raw;
    if (t == TCM_TYPE_BAD) return VAL_BADTYPE;
    gain = (t == TCM_TYPE_L) ? int'(GAIN_L) : (t == TCM_TYPE_J) ? int'(GAIN_J) : int'(GAIN_K);
    sum = comp + ((int'($signed(raw)) * gain) >>> GAIN_SHIFT);
    if (sum > 32767) return 16'h7FFF;
    if (sum < -32768) return 16'h8000;
    return 16'(sum);
  endfunction : exp_meas

  // ****************************************************************
  // result watcher: one note taken per stored channel
  // ****************************************************************
  always @(negedge clock_i) begin
    if (!sys_rst_i && conv_ch !== last_ch) begin
      if (notes.size() > 0) begin
        tcm_note_t n;
        n = notes.pop_front();
        check(16'(last_ch), 16'(n.ch), "channel order");
        check(meas_word[last_ch], n.meas, "channel word");
        check(comp_word[last_ch], n.comp, "compensation word");
        check(raw_word[last_ch], n.raw, "raw word");
      end
      last_ch = conv_ch;
    end
  end

  task automatic wait_start(input logic any, input logic [2:0] ch);
    int n;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (!(conv_start === 1'b1 && (any || conv_ch === ch)) && n < 500);
  endtask : wait_start

  // one full scan, types and compensation source from the index, formats random from scan 4
  task automatic run_scan(input int i);
    logic [7:0] m2, m3, m4;
    int n;
    m2 = {4'h0, 2'(i + 1), 2'(i)};
    // first four scans report temperatures so every type code is seen
    m3 = (i >= 4) ? (8'($random(seed)) & MODE3_MASK) : 8'h00;
    m4 = i[0] ? 8'h20 : 8'h00;
    wait_start(1'b0, 3'h7);
    i_host.write_mode(MODE2_IDX, m2);
    i_host.write_mode(MODE3_IDX, m3);
    i_host.write_mode(MODE4_IDX, m4);
    i_host.load_refs({$random(seed), $random(seed), $random(seed), $random(seed)});
    adc_raw   <= {$random(seed), $random(seed), $random(seed), $random(seed)};
    term_temp <= {$random(seed), $random(seed), $random(seed), $random(seed)};
    adc_over  <= 8'($random(seed) & $random(seed) & $random(seed));
    adc_under <= 8'($random(seed) & $random(seed) & $random(seed));
    n = 0;
    while (conv_ch !== 3'h0 && n < 500) begin
      @(posedge clock_i);
      n++;
    end
    for (int ch = 0; ch < NUM_CH; ch++) begin
      logic g;
      g = ch[GRP_BIT];
      notes.push_back('{3'(ch),
        exp_meas(g ? m2[3:2] : m2[1:0], m3[g ? 1 : 0], m3[g ? 5 : 4], adc_over[ch],
                 adc_under[ch], m4[M4_REMOTE], adc_raw[ch], term_temp[ch], ext_ref[ch]),
        term_temp[ch], adc_raw[ch]});
    end
    n = 0;
    while (notes.size() > 0 && n < 1000) begin
      @(posedge clock_i);
      n++;
    end
    check(16'(notes.size()), 16'h0000, "results missing");
    notes.delete();
    check(16'(stat2), 16'(m2), "type echo");
    check(16'(stat3), 16'(m3), "format echo");
    check(16'(stat4), 16'(m4), "compensation echo");
    check(16'(stat1), 16'(STAT1_OK), "module status");
    $display("scan %0d done", i);
  endtask : run_scan

  // conversion period of one mode 1 setting, start to start
  task automatic period_case(input logic [7:0] m1, input int per);
    int n;
    wait_start(1'b1, 3'h0);
    i_host.write_mode(MODE1_IDX, m1);
    wait_start(1'b1, 3'h0);
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (conv_start !== 1'b1 && n < 100);
    check(16'(n), 16'(per + 2), "conversion period");
    $display("period case %h done", m1);
  endtask : period_case

  // ****************************************************************
  // main sequence and watchdog
  // ****************************************************************
  initial begin
    seed = 41964;
    fails = 0;
    compares = 0;
    sys_rst_i = 1'b1;
    adc_raw = '0;
    adc_over = '0;
    adc_under = '0;
    term_temp = '0;
    repeat (4) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    @(negedge clock_i);
    check({stat4, stat3}, 16'h0000, "echo after reset");
    check({stat2, stat1}, 16'h0000, "status after reset");
    check(meas_word[0], 16'h0000, "word after reset");
    $display("reset test done");
    period_case(8'h00, P50);
    period_case(8'h01, P60);
    period_case(8'h80, P50 / 2);
    period_case(8'h81, P60 / 2);
    for (int i = 0; i < 8; i++) run_scan(i);
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge clock_i);
    fails++;
    stop_test();
  end
endmodule : thermocouple_input_mode_control_tb_top
